// ### shst_pkg.sv
// package for the stop hold and saturation fault timer
// assumes a 50 MHz system clock
`default_nettype none
package shst_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_FREQ_HZ = 50000000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = (CLK_FREQ_HZ / 1000) * TICK_MS;
   localparam int HOLD_STEP_MS = 2;
   // ----------------------------------------
   // setting ranges and reset values
   // ----------------------------------------
   localparam logic [13:0] HOLD_MAX_MS = 14'h2710;
   localparam logic [13:0] HOLD_RESET_MS = 14'h0000;
   localparam logic [12:0] SAT_MAX_MS = 13'h1388;
   localparam logic [12:0] SAT_RESET_MS = 13'h0000;
   typedef enum {HOLD_IDLE, HOLD_RUN, HOLD_DONE} shst_hold_state_t;
   typedef struct packed {
      logic [13:0] holdMs;
      logic [12:0] satMs;
   } shst_cfg_t;
   typedef struct packed {
      logic brakeReleaseOutput;
      logic motorCurrentEnable;
      logic torqueSaturationAlarm;
   } shst_status_t;
endpackage
`default_nettype wire

// ### shst_tick.sv
// millisecond tick generator
// assumes one clock, enable freezes the count
`default_nettype none
module shst_tick #(parameter int CYCLES = shst_pkg::TICK_CYCLES)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic en,
   output logic tick
);
   logic [31:0] count;
   assign tick = en && (count == 32'(CYCLES - 1));
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         count <= 32'h0;
      else if (en)
         count <= tick ? 32'h0 : count + 32'h1;
   end
endmodule // shst_tick
`default_nettype wire

// ### shst_sync.sv
// two flip-flop synchroniser for a pin level
// assumes the pin is asynchronous to clk
`default_nettype none
module shst_sync
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic en,
   input wire logic pin,
   output logic level
);
   logic stage1;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stage1 <= 1'b0;
         level <= 1'b0;
      end
      else if (en)
      begin
         stage1 <= pin;
         level <= stage1;
      end
   end
endmodule // shst_sync
`default_nettype wire

// ### shst_timer.sv
// stop hold and torque saturation fault timer
// assumes settings come from registers on clk; stop alarm and torque limit are pins
// What this block does
// - on a stop alarm, drop brake release and keep motor current for the hold time
// - hold time setting spans 0 to 10000 ms, default 0
// - hold time counts in 2 ms steps, odd settings round up
// - raise saturation alarm once torque limiting lasts longer than detect time
// - detect time zero disables the saturation alarm
`default_nettype none
module shst_timer #(parameter int TICK_CYCLES = shst_pkg::TICK_CYCLES)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [1:0] regAddr,
   input wire logic [15:0] regWdata,
   output logic [15:0] regRdata,
   input wire logic stopAlarmPin,
   input wire logic torqueLimitPin,
   input wire logic alarmClear,
   output shst_pkg::shst_status_t status
);
   // ----------------------------------------
   // settings, addr 0 hold ms, 1 detect ms, 2 status
   // ----------------------------------------
   shst_pkg::shst_cfg_t cfg;
   logic tick, stopAlarm, torqueLimit;
   logic [13:0] clampHold;
   logic [12:0] clampSat;
   assign clampHold = (regWdata[13:0] > shst_pkg::HOLD_MAX_MS) ? shst_pkg::HOLD_MAX_MS : regWdata[13:0];
   assign clampSat = (regWdata[12:0] > shst_pkg::SAT_MAX_MS) ? shst_pkg::SAT_MAX_MS : regWdata[12:0];
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cfg.holdMs <= shst_pkg::HOLD_RESET_MS;
         cfg.satMs <= shst_pkg::SAT_RESET_MS;
         regRdata <= 16'h0;
      end
      else if (clkEn)
      begin
         if (regWrite && regAddr == 2'h0)
            cfg.holdMs <= clampHold;
         if (regWrite && regAddr == 2'h1)
            cfg.satMs <= clampSat;
         regRdata <= !regRead ? 16'h0 : (regAddr == 2'h0) ? {2'h0, cfg.holdMs} :
            (regAddr == 2'h1) ? {3'h0, cfg.satMs} : (regAddr == 2'h2) ? {13'h0, status} : 16'h0;
      end
   end
   shst_tick #(.CYCLES(TICK_CYCLES)) tickGen (.clk(clk), .rst_b(rst_b), .en(clkEn), .tick(tick));
   shst_sync stopSync (.clk(clk), .rst_b(rst_b), .en(clkEn), .pin(stopAlarmPin), .level(stopAlarm));
   shst_sync limSync (.clk(clk), .rst_b(rst_b), .en(clkEn), .pin(torqueLimitPin), .level(torqueLimit));
   // ----------------------------------------
   // stop hold
   // ----------------------------------------
   // counts ms ticks up to the setting rounded up to even; one-tick phase uncertainty remains
   shst_pkg::shst_hold_state_t holdState;
   logic [13:0] holdCount, holdTarget;
   assign holdTarget = cfg.holdMs + {13'h0, cfg.holdMs[0]};
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         holdState <= shst_pkg::HOLD_IDLE;
         holdCount <= 14'h0;
      end
      else if (clkEn)
      begin
         case (holdState)
            shst_pkg::HOLD_IDLE:
               if (stopAlarm)
               begin
                  holdCount <= 14'h0;
                  holdState <= (holdTarget == 14'h0) ? shst_pkg::HOLD_DONE : shst_pkg::HOLD_RUN;
               end
            shst_pkg::HOLD_RUN:
               if (tick)
               begin
                  holdCount <= holdCount + 14'h1;
                  if (holdCount + 14'h1 >= holdTarget)
                     holdState <= shst_pkg::HOLD_DONE;
               end
            shst_pkg::HOLD_DONE:
               if (!stopAlarm)
                  holdState <= shst_pkg::HOLD_IDLE;
            default:
               holdState <= shst_pkg::HOLD_IDLE;
         endcase
      end
   end
   assign status.brakeReleaseOutput = !stopAlarm && holdState == shst_pkg::HOLD_IDLE;
   assign status.motorCurrentEnable = holdState != shst_pkg::HOLD_DONE;
   // ----------------------------------------
   // torque saturation
   // ----------------------------------------
   // alarm latches until cleared; a fresh trip wins over a clear in the same cycle
   logic [12:0] satCount;
   logic satAlarm, satTrip;
   assign satTrip = torqueLimit && cfg.satMs != 13'h0 && tick && satCount >= cfg.satMs;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         satCount <= 13'h0;
         satAlarm <= 1'b0;
      end
      else if (clkEn)
      begin
         if (!torqueLimit || cfg.satMs == 13'h0)
            satCount <= 13'h0;
         else if (tick && satCount < cfg.satMs)
            satCount <= satCount + 13'h1;
         if (satTrip)
            satAlarm <= 1'b1;
         else if (alarmClear)
            satAlarm <= 1'b0;
      end
   end
   assign status.torqueSaturationAlarm = satAlarm;
   // ----------------------------------------
   // checks
   // ----------------------------------------
   sat_disabled_a: assert property (@(posedge clk) disable iff (!rst_b)
      (cfg.satMs == 13'h0 && !satAlarm) |=> !satAlarm) else $error("alarm with detect off");
   sat_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
      (clkEn && !torqueLimit) |=> satCount == 13'h0) else $error("count not cleared");
   sat_trip_a: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(satAlarm) |-> $past(torqueLimit) && $past(satCount) == cfg.satMs) else $error("early trip");
   hold_brake_a: assert property (@(posedge clk) disable iff (!rst_b)
      stopAlarm |-> !status.brakeReleaseOutput) else $error("brake not dropped");
   hold_even_a: assert property (@(posedge clk) disable iff (!rst_b)
      holdTarget[0] == 1'b0) else $error("odd hold target");
   hold_range_a: assert property (@(posedge clk) disable iff (!rst_b)
      cfg.holdMs <= shst_pkg::HOLD_MAX_MS) else $error("hold out of range");
   hold_end_a: assert property (@(posedge clk) disable iff (!rst_b)
      (holdState == shst_pkg::HOLD_RUN && clkEn && tick && holdCount + 14'h1 >= holdTarget)
      |=> !status.motorCurrentEnable)
      else $error("hold did not end");
   hold_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
      (holdState == shst_pkg::HOLD_RUN) |-> status.motorCurrentEnable) else $error("current dropped early");
   hold_done_c: cover property (@(posedge clk) disable iff (!rst_b) $rose(holdState == shst_pkg::HOLD_DONE));
   sat_trip_c: cover property (@(posedge clk) disable iff (!rst_b) $rose(satAlarm));
   sat_reset_c: cover property (@(posedge clk) disable iff (!rst_b) satCount != 13'h0 ##1 satCount == 13'h0);
endmodule // shst_timer
`default_nettype wire

// ### shst_brake_model.sv
// far-side model: the holding brake and the load it holds
// assumes status comes straight from the timer
`default_nettype none
module shst_brake_model
(
   input wire logic clk,
   input wire logic rst_b,
   input wire shst_pkg::shst_status_t status,
   output logic [15:0] holdCycles
);
   timeunit 1ns;
   timeprecision 1ns;
   // cycles with brake set and current still on; frozen once current stops
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         holdCycles <= 16'h0000;
      else if (status.brakeReleaseOutput)
         holdCycles <= 16'h0000;
      else if (status.motorCurrentEnable)
         holdCycles <= holdCycles + 16'h0001;
   end
endmodule // shst_brake_model
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the stop hold and saturation timer
// assumes a tick of 5 clocks stands for 1 ms
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TK = 5;
   logic clk = 1'b0, rst_b = 1'b0, regWrite = 1'b0, regRead = 1'b0, rdPend = 1'b0;
   logic stopPin = 1'b0, limPin = 1'b0, clr = 1'b0;
   logic [1:0] regAddr = 2'h0;
   logic [15:0] regWdata = 16'h0000, regRdata, holdCycles;
   logic [15:0] expQ[$];
   logic [31:0] seed = 32'h00000031;
   shst_pkg::shst_status_t status;
   int failures = 0, checked = 0;
   shst_timer #(.TICK_CYCLES(TK)) u_dut (.clk(clk), .rst_b(rst_b), .clkEn(1'b1), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .stopAlarmPin(stopPin),
      .torqueLimitPin(limPin), .alarmClear(clr), .status(status));
   shst_brake_model u_brake (.clk(clk), .rst_b(rst_b), .status(status), .holdCycles(holdCycles));
   initial forever #10 clk = ~clk;
   task automatic end_of_test();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0] % 16'h2711;
   endfunction
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [15:0] e);
      expQ.push_back(e);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      @(posedge clk);
   endtask
   // read data is due exactly one cycle after the strobe
   always @(posedge clk)
   begin
      if (rdPend)
         chk("regRdata", expQ.pop_front(), regRdata);
      rdPend <= regRead;
   end
   // tick phase is free-running, so allow one tick early and sync slack late
   task automatic hold(input logic [15:0] ms, input int ticks);
      wr(2'h0, ms);
      stopPin <= 1'b1;
      repeat (4) @(posedge clk);
      chk("brake", 16'h0000, {15'h0000, status.brakeReleaseOutput});
      for (int i = 0; i < 300 && status.motorCurrentEnable; i++)
         @(posedge clk);
      chk("current", 16'h0000, {15'h0000, status.motorCurrentEnable});
      chk("holdWin", 16'h0001, {15'h0000, int'(holdCycles) >= (ticks - 1) * TK && int'(holdCycles) <= ticks * TK + 4});
      stopPin <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   task automatic sat(input int cyc, input logic e);
      limPin <= 1'b1;
      repeat (cyc) @(posedge clk);
      limPin <= 1'b0;
      repeat (4) @(posedge clk);
      chk("alarm", {15'h0000, e}, {15'h0000, status.torqueSaturationAlarm});
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
   endtask
   initial
   begin
      logic [15:0] v;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(2'h0, 16'h0000);
      rd(2'h1, 16'h0000);
      rd(2'h3, 16'h0000);
      for (int i = 0; i < 4; i++)
      begin
         v = rnd();
         wr(2'h0, v);
         rd(2'h0, v);
      end
      wr(2'h0, 16'h3fff);
      rd(2'h0, 16'h2710);
      wr(2'h1, 16'h1fff);
      rd(2'h1, 16'h1388);
      hold(16'h0000, 0);
      hold(16'h0002, 2);
      hold(16'h0003, 4);
      hold(16'h000b, 12);
      wr(2'h1, 16'h0003);
      sat(8, 1'b0);
      sat(8, 1'b0);
      sat(30, 1'b1);
      wr(2'h1, 16'h0000);
      sat(40, 1'b0);
      end_of_test();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      failures++;
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire
